// [pkg/iep_pkg.sv]
package iep_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] MAIN_MASK_ADDR = 8'ha8;
  localparam logic [7:0] MAIN_LEVEL_ADDR = 8'hb8;
  localparam logic [7:0] EXT_CFG_ADDR = 8'he4;
  localparam logic [7:0] EXT_MASK1_ADDR = 8'he6;
  localparam logic [7:0] EXT_MASK2_ADDR = 8'he7;
  localparam logic [7:0] EXT_LEVEL1_ADDR = 8'hf6;
  localparam logic [7:0] EXT_LEVEL2_ADDR = 8'hf7;

  // ==========================================================
  // reset values
  localparam logic [7:0] MAIN_MASK_RST = 8'h00;
  localparam logic [7:0] MAIN_LEVEL_RST = 8'h80;
  localparam logic [7:0] EXT_CFG_RST = 8'h01;
  localparam logic [7:0] EXT_MASK1_RST = 8'h00;
  localparam logic [7:0] EXT_MASK2_RST = 8'h00;
  localparam logic [7:0] EXT_LEVEL1_RST = 8'h00;
  localparam logic [7:0] EXT_LEVEL2_RST = 8'h00;

  // ==========================================================
  // field layout
  localparam int GATE_BIT = 7;
  localparam logic [7:0] MAIN_LEVEL_FIXED = 8'h80;
  localparam logic [7:0] EXT_TWO_WMASK = 8'h03;
  localparam int IN1_POL_BIT = 7;
  localparam int IN1_SEL_LSB = 4;
  localparam int IN0_POL_BIT = 3;
  localparam int IN0_SEL_LSB = 0;
  localparam int SEL_W = 3;

  // ==========================================================
  // source numbering, also the fixed arbitration order
  localparam int NUM_SRC = 17;
  localparam int IDX_W = 5;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_T1 = 3;
  localparam int SRC_S0 = 4;
  localparam int SRC_T2 = 5;
  localparam int SRC_SPI = 6;
  localparam int SRC_SMB = 7;
  localparam int SRC_USB = 8;
  localparam int SRC_WIN = 9;
  localparam int SRC_ADC = 10;
  localparam int SRC_PCA = 11;
  localparam int SRC_CP0 = 12;
  localparam int SRC_CP1 = 13;
  localparam int SRC_T3 = 14;
  localparam int SRC_VBUS = 15;
  localparam int SRC_S1 = 16;

  // ==========================================================
  // service nesting state
  typedef enum logic [1:0] {
    IEP_SVC_IDLE,
    IEP_SVC_LOW,
    IEP_SVC_HIGH,
    IEP_SVC_HIGH_OVER_LOW
  } iep_svc_t;
endpackage : iep_pkg

// [hw/iep_pin_sync.sv]
// three-stage synchroniser for the port pins; a change is taken
// only once the second and third stages agree
module iep_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pins and filtered result
  input wire logic [WIDTH-1:0] pins_async,
  output logic [WIDTH-1:0] pins_stable
);
  import iep_pkg::*;

  // ==========================================================
  // synchroniser stages
  logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, stable_reg;
  logic [WIDTH-1:0] stable_next;

  // per bit: take the new value only when stages two and three match
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      stable_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : stable_reg[i];
    end
  end

  // stage one feeds stage two only; reset to the pulled-up idle level so
  // releasing reset cannot fake an edge on an idle pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
      stage3_reg <= '1;
      stable_reg <= '1;
    end else begin
      stage1_reg <= pins_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_reg <= stable_next;
    end
  end

  assign pins_stable = stable_reg;
endmodule : iep_pin_sync

// [hw/iep_regs.sv]
module iep_regs #(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // special function register access
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr_en,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wdata,
  output logic [7:0] sfr_rdata,
  // core service handshake
  input wire logic vector_ack,
  input wire logic reti_done,
  output logic irq_req,
  output logic irq_high,
  output logic [iep_pkg::IDX_W-1:0] irq_index,
  output logic [iep_pkg::NUM_SRC-1:0] src_request,
  // external inputs
  input wire logic [PIN_COUNT-1:0] port0_pins,
  input wire logic [1:0] ext_edge_mode,
  output logic [1:0] ext_pending,
  // peripheral flags
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic [1:0] serial0_flags,
  input wire logic timer2_low_overflow,
  input wire logic timer2_high_overflow,
  input wire logic [3:0] spi_flags,
  input wire logic smbus_flag,
  input wire logic usb_flag,
  input wire logic window_compare_flag,
  input wire logic conversion_done_flag,
  input wire logic counter_array_flag,
  input wire logic comparator0_rising_flag,
  input wire logic comparator0_falling_flag,
  input wire logic comparator1_rising_flag,
  input wire logic comparator1_falling_flag,
  input wire logic timer3_low_overflow,
  input wire logic timer3_high_overflow,
  input wire logic bus_voltage_flag,
  input wire logic [1:0] serial1_flags
);
  import iep_pkg::*;

  // ==========================================================
  // elaboration check: pin select is three bits wide
  if (PIN_COUNT != 8) begin : g_bad_pins
    $error("iep_regs: PIN_COUNT must be 8");
  end

  // lowest set index wins, which is the fixed order
  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) idx = IDX_W'(i);
    end
    return idx;
  endfunction : first_set

  // bit writes address eight consecutive bits of one register
  function automatic logic bit_hits(input logic [7:0] badr, input logic [7:0] base);
    return badr[7:3] == base[7:3];
  endfunction : bit_hits

  // ==========================================================
  // register file
  logic [7:0] main_irq_mask_reg, main_irq_mask_next;
  logic [7:0] main_irq_level_reg, main_irq_level_next;
  logic [7:0] ext_input_config_reg, ext_input_config_next;
  logic [7:0] extended_mask_one_reg, extended_mask_one_next;
  logic [7:0] extended_mask_two_reg, extended_mask_two_next;
  logic [7:0] extended_level_one_reg, extended_level_one_next;
  logic [7:0] extended_level_two_reg, extended_level_two_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;

  // byte writes, then single-bit writes on the bit-addressable pair
  always_comb begin
    main_irq_mask_next = main_irq_mask_reg;
    main_irq_level_next = main_irq_level_reg;
    ext_input_config_next = ext_input_config_reg;
    extended_mask_one_next = extended_mask_one_reg;
    extended_mask_two_next = extended_mask_two_reg;
    extended_level_one_next = extended_level_one_reg;
    extended_level_two_next = extended_level_two_reg;
    if (sfr_wr_en) begin
      case (sfr_addr)
        MAIN_MASK_ADDR: main_irq_mask_next = sfr_wdata;
        MAIN_LEVEL_ADDR: main_irq_level_next = sfr_wdata | MAIN_LEVEL_FIXED;
        EXT_CFG_ADDR: ext_input_config_next = sfr_wdata;
        EXT_MASK1_ADDR: extended_mask_one_next = sfr_wdata;
        EXT_MASK2_ADDR: extended_mask_two_next = sfr_wdata & EXT_TWO_WMASK;
        EXT_LEVEL1_ADDR: extended_level_one_next = sfr_wdata;
        EXT_LEVEL2_ADDR: extended_level_two_next = sfr_wdata & EXT_TWO_WMASK;
        default: ;
      endcase
    end
    if (bit_wr_en && bit_hits(bit_addr, MAIN_MASK_ADDR)) begin
      main_irq_mask_next[bit_addr[2:0]] = bit_wdata;
    end
    if (bit_wr_en && bit_hits(bit_addr, MAIN_LEVEL_ADDR) && (bit_addr[2:0] != 3'(GATE_BIT))) begin
      main_irq_level_next[bit_addr[2:0]] = bit_wdata;
    end
  end

  // read data, unmapped addresses return zero
  always_comb begin
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_rd_en) begin
      case (sfr_addr)
        MAIN_MASK_ADDR: sfr_rdata_next = main_irq_mask_reg;
        MAIN_LEVEL_ADDR: sfr_rdata_next = main_irq_level_reg;
        EXT_CFG_ADDR: sfr_rdata_next = ext_input_config_reg;
        EXT_MASK1_ADDR: sfr_rdata_next = extended_mask_one_reg;
        EXT_MASK2_ADDR: sfr_rdata_next = extended_mask_two_reg;
        EXT_LEVEL1_ADDR: sfr_rdata_next = extended_level_one_reg;
        EXT_LEVEL2_ADDR: sfr_rdata_next = extended_level_two_reg;
        default: sfr_rdata_next = 8'h00;
      endcase
    end
  end

  // registers reset to their documented values; every level starts low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      main_irq_mask_reg <= MAIN_MASK_RST;
      main_irq_level_reg <= MAIN_LEVEL_RST;
      ext_input_config_reg <= EXT_CFG_RST;
      extended_mask_one_reg <= EXT_MASK1_RST;
      extended_mask_two_reg <= EXT_MASK2_RST;
      extended_level_one_reg <= EXT_LEVEL1_RST;
      extended_level_two_reg <= EXT_LEVEL2_RST;
      sfr_rdata_reg <= 8'h00;
    end else begin
      main_irq_mask_reg <= main_irq_mask_next;
      main_irq_level_reg <= main_irq_level_next;
      ext_input_config_reg <= ext_input_config_next;
      extended_mask_one_reg <= extended_mask_one_next;
      extended_mask_two_reg <= extended_mask_two_next;
      extended_level_one_reg <= extended_level_one_next;
      extended_level_two_reg <= extended_level_two_next;
      sfr_rdata_reg <= sfr_rdata_next;
    end
  end

  // ==========================================================
  // external inputs: watch-only taps on port 0, never driven
  logic [PIN_COUNT-1:0] pins_stable;
  logic [1:0] ext_active, ext_edge;
  logic [1:0] ext_active_prev_reg, ext_active_prev_next;
  logic [1:0] ext_flag_reg, ext_flag_next;

  iep_pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins_async(port0_pins),
    .pins_stable(pins_stable)
  );

  // pin select then polarity; a select change may fake one edge
  always_comb begin
    ext_active[0] = pins_stable[ext_input_config_reg[IN0_SEL_LSB +: SEL_W]]
                    ~^ ext_input_config_reg[IN0_POL_BIT];
    ext_active[1] = pins_stable[ext_input_config_reg[IN1_SEL_LSB +: SEL_W]]
                    ~^ ext_input_config_reg[IN1_POL_BIT];
    ext_edge = ext_active & ~ext_active_prev_reg;
    ext_active_prev_next = ext_active;
  end

  // ==========================================================
  // gating and arbitration
  logic [NUM_SRC-1:0] raw_flags, src_mask, src_level, gated, cand_high, cand_low;
  logic [NUM_SRC-1:0] src_request_reg, src_request_next;
  logic irq_req_reg, irq_req_next;
  logic irq_high_reg, irq_high_next;
  logic [IDX_W-1:0] irq_index_reg, irq_index_next;
  iep_svc_t svc_reg, svc_next;

  // per-source pending terms
  always_comb begin
    raw_flags[SRC_EXT0] = ext_flag_reg[0];
    raw_flags[SRC_T0] = timer0_overflow;
    raw_flags[SRC_EXT1] = ext_flag_reg[1];
    raw_flags[SRC_T1] = timer1_overflow;
    raw_flags[SRC_S0] = |serial0_flags;
    raw_flags[SRC_T2] = timer2_low_overflow | timer2_high_overflow;
    raw_flags[SRC_SPI] = |spi_flags;
    raw_flags[SRC_SMB] = smbus_flag;
    raw_flags[SRC_USB] = usb_flag;
    raw_flags[SRC_WIN] = window_compare_flag;
    raw_flags[SRC_ADC] = conversion_done_flag;
    raw_flags[SRC_PCA] = counter_array_flag;
    raw_flags[SRC_CP0] = comparator0_rising_flag | comparator0_falling_flag;
    raw_flags[SRC_CP1] = comparator1_rising_flag | comparator1_falling_flag;
    raw_flags[SRC_T3] = timer3_low_overflow | timer3_high_overflow;
    raw_flags[SRC_VBUS] = bus_voltage_flag;
    raw_flags[SRC_S1] = |serial1_flags;
    src_mask = {extended_mask_two_reg[1:0], extended_mask_one_reg, main_irq_mask_reg[6:0]};
    src_level = {extended_level_two_reg[1:0], extended_level_one_reg, main_irq_level_reg[6:0]};
    gated = raw_flags & src_mask & {NUM_SRC{main_irq_mask_reg[GATE_BIT]}};
    cand_high = gated & src_level;
    cand_low = gated & ~src_level;
    src_request_next = gated;
  end

  // nesting: high may interrupt low, nothing interrupts high
  always_comb begin
    svc_next = svc_reg;
    if (vector_ack && irq_req_reg) begin
      case (svc_reg)
        IEP_SVC_IDLE: svc_next = irq_high_reg ? IEP_SVC_HIGH : IEP_SVC_LOW;
        IEP_SVC_LOW: svc_next = irq_high_reg ? IEP_SVC_HIGH_OVER_LOW : IEP_SVC_LOW;
        default: svc_next = svc_reg;
      endcase
    end else if (reti_done) begin
      case (svc_reg)
        IEP_SVC_HIGH_OVER_LOW: svc_next = IEP_SVC_LOW;
        IEP_SVC_HIGH: svc_next = IEP_SVC_IDLE;
        IEP_SVC_LOW: svc_next = IEP_SVC_IDLE;
        default: svc_next = IEP_SVC_IDLE;
      endcase
    end
    // request is judged against the state the core will be in next
    irq_req_next = 1'b0;
    irq_high_next = 1'b0;
    irq_index_next = '0;
    if (svc_next != IEP_SVC_HIGH && svc_next != IEP_SVC_HIGH_OVER_LOW) begin
      if (|cand_high) begin
        irq_req_next = 1'b1;
        irq_high_next = 1'b1;
        irq_index_next = first_set(cand_high);
      end else if (svc_next == IEP_SVC_IDLE && |cand_low) begin
        irq_req_next = 1'b1;
        irq_index_next = first_set(cand_low);
      end
    end
  end

  // edge flags: set wins over the vectoring clear; level mode follows the input
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (ext_edge_mode[k]) begin
        ext_flag_next[k] = ext_flag_reg[k];
        if (vector_ack && irq_req_reg && irq_index_reg == IDX_W'(k == 0 ? SRC_EXT0 : SRC_EXT1)) begin
          ext_flag_next[k] = 1'b0;
        end
        if (ext_edge[k]) ext_flag_next[k] = 1'b1;
      end else begin
        ext_flag_next[k] = ext_active[k];
      end
    end
  end

  // state and output registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_active_prev_reg <= 2'h0;
      ext_flag_reg <= 2'h0;
      src_request_reg <= '0;
      irq_req_reg <= 1'b0;
      irq_high_reg <= 1'b0;
      irq_index_reg <= '0;
      svc_reg <= IEP_SVC_IDLE;
    end else begin
      ext_active_prev_reg <= ext_active_prev_next;
      ext_flag_reg <= ext_flag_next;
      src_request_reg <= src_request_next;
      irq_req_reg <= irq_req_next;
      irq_high_reg <= irq_high_next;
      irq_index_reg <= irq_index_next;
      svc_reg <= svc_next;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign irq_req = irq_req_reg;
  assign irq_high = irq_high_reg;
  assign irq_index = irq_index_reg;
  assign src_request = src_request_reg;
  assign ext_pending = ext_flag_reg;

  // ==========================================================
  // assertions
  property p_gate_off;
    @(posedge ref_clk) disable iff (!nrst)
    !main_irq_mask_reg[GATE_BIT] |=> !irq_req_reg && (src_request_reg == '0);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request with global gate clear");

  property p_timer1;
    @(posedge ref_clk) disable iff (!nrst)
    timer1_overflow && main_irq_mask_reg[GATE_BIT] |->
      ##1 (src_request_reg[SRC_T1] == $past(main_irq_mask_reg[SRC_T1]));
  endproperty
  a_timer1: assert property (p_timer1) else $error("timer1 request not following its mask");

  property p_timer2;
    @(posedge ref_clk) disable iff (!nrst)
    (timer2_low_overflow ^ timer2_high_overflow) && main_irq_mask_reg[GATE_BIT] && main_irq_mask_reg[SRC_T2]
      |=> src_request_reg[SRC_T2];
  endproperty
  a_timer2: assert property (p_timer2) else $error("timer2 single flag not passed");

  property p_timer3;
    @(posedge ref_clk) disable iff (!nrst)
    timer3_high_overflow && main_irq_mask_reg[GATE_BIT] && extended_mask_one_reg[7] |=> src_request_reg[SRC_T3];
  endproperty
  a_timer3: assert property (p_timer3) else $error("timer3 high flag not passed");

  property p_cmp_fall;
    @(posedge ref_clk) disable iff (!nrst)
    comparator1_falling_flag && main_irq_mask_reg[GATE_BIT] && extended_mask_one_reg[6] |=> src_request_reg[SRC_CP1];
  endproperty
  a_cmp_fall: assert property (p_cmp_fall) else $error("comparator falling flag not passed");

  property p_conv_window;
    @(posedge ref_clk) disable iff (!nrst)
    window_compare_flag && !extended_mask_one_reg[3] && extended_mask_one_reg[2] && main_irq_mask_reg[GATE_BIT]
      |=> src_request_reg[SRC_WIN] && !src_request_reg[SRC_ADC];
  endproperty
  a_conv_window: assert property (p_conv_window) else $error("window and conversion masks coupled");

  property p_two_unused;
    @(posedge ref_clk) disable iff (!nrst)
    extended_mask_two_reg[7:2] == 6'h00 && extended_level_two_reg[7:2] == 6'h00 && main_irq_level_reg[GATE_BIT];
  endproperty
  a_two_unused: assert property (p_two_unused) else $error("unused bits changed");

  property p_high_wins;
    @(posedge ref_clk) disable iff (!nrst)
    svc_reg == IEP_SVC_LOW && !vector_ack && !reti_done && (|cand_high) |=> irq_req_reg && irq_high_reg;
  endproperty
  a_high_wins: assert property (p_high_wins) else $error("high request did not preempt low");

  property p_no_preempt_high;
    @(posedge ref_clk) disable iff (!nrst)
    svc_reg == IEP_SVC_HIGH && !reti_done |=> !irq_req_reg;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high service preempted");

  property p_edge_clear;
    @(posedge ref_clk) disable iff (!nrst)
    vector_ack && irq_req_reg && irq_index_reg == IDX_W'(SRC_EXT0) && ext_edge_mode[0] && !ext_edge[0]
      |=> !ext_flag_reg[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared on vectoring");
endmodule : iep_regs

// [dv/iep_flag_src.sv]
// ==========================================================
// peripheral flag and port pin sources
module iep_flag_src (
  // clock
  input wire logic ref_clk,
  // levels asked for by the sequence
  input wire logic [23:0] flag_req,
  input wire logic [7:0] pin_req,
  // levels seen by the controller
  output logic [23:0] flags,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // move on the falling edge, clear of the sampling edge; first update
  // lands while reset is still held
  always @(negedge ref_clk) begin
    flags <= flag_req;
    pins <= pin_req;
  end
endmodule : iep_flag_src

// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iep_pkg::*;
  // ==========================================================
  // register table: address, writable bits, fixed ones, reset
  localparam logic [7:0] ADR [7] = '{8'ha8, 8'hb8, 8'he4, 8'he6, 8'he7, 8'hf6, 8'hf7};
  localparam logic [7:0] WM [7] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'h03, 8'hff, 8'h03};
  localparam logic [7:0] FX [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST [7] = '{8'h00, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic ref_clk, nrst, sfr_wr_en, sfr_rd_en, bit_wr_en, bit_wdata, vector_ack, reti_done, irq_req, irq_high;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, pin_req, pins;
  logic [1:0] ext_edge_mode, ext_pending;
  logic [IDX_W-1:0] irq_index;
  logic [NUM_SRC-1:0] src_request;
  logic [23:0] flag_req, fl;
  logic [7:0] sh [7];
  logic [31:0] rnd, rnd2;
  int error_cnt, check_count, seed;
  // ==========================================================
  // design and flag sources
  iep_flag_src src (.ref_clk(ref_clk), .flag_req(flag_req), .pin_req(pin_req), .flags(fl), .pins(pins));
  iep_regs #(.PIN_COUNT(8)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .bit_wr_en(bit_wr_en), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .sfr_rdata(sfr_rdata), .vector_ack(vector_ack), .reti_done(reti_done), .irq_req(irq_req),
    .irq_high(irq_high), .irq_index(irq_index), .src_request(src_request), .port0_pins(pins),
    .ext_edge_mode(ext_edge_mode), .ext_pending(ext_pending), .timer0_overflow(fl[0]),
    .timer1_overflow(fl[1]), .serial0_flags(fl[3:2]), .timer2_low_overflow(fl[4]),
    .timer2_high_overflow(fl[5]), .spi_flags(fl[9:6]), .smbus_flag(fl[10]), .usb_flag(fl[11]),
    .window_compare_flag(fl[12]), .conversion_done_flag(fl[13]), .counter_array_flag(fl[14]),
    .comparator0_rising_flag(fl[15]), .comparator0_falling_flag(fl[16]), .comparator1_rising_flag(fl[17]),
    .comparator1_falling_flag(fl[18]), .timer3_low_overflow(fl[19]), .timer3_high_overflow(fl[20]),
    .bus_voltage_flag(fl[21]), .serial1_flags(fl[23:22]));
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // compare, report and bus tasks; every task starts just after a falling edge
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // strobes drop for a full cycle between accesses, so no signal is driven twice in one step
  task automatic wr(input int r, input logic [7:0] d);
    sfr_wr_en = 1'b1;
    sfr_addr = ADR[r];
    sfr_wdata = d;
    sh[r] = (d & WM[r]) | FX[r];
    @(negedge ref_clk);
    sfr_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_rd_en = 1'b1;
    sfr_addr = a;
    @(negedge ref_clk);
    sfr_rd_en = 1'b0;
    check(sfr_rdata, e);
    @(negedge ref_clk);
  endtask : rd
  task automatic bw(input logic [7:0] a, input logic v);
    int r;
    r = (a[7:4] == 4'ha) ? 0 : 1;
    bit_wr_en = 1'b1;
    bit_addr = a;
    bit_wdata = v;
    sh[r][a[2:0]] = v;
    sh[r] = (sh[r] & WM[r]) | FX[r];
    @(negedge ref_clk);
    bit_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask : bw
  task automatic pulse(input logic a, input logic r);
    vector_ack = a;
    reti_done = r;
    @(negedge ref_clk);
    vector_ack = 1'b0;
    reti_done = 1'b0;
    @(negedge ref_clk);
  endtask : pulse
  // the pin path is a synchroniser, so only a bounded wait fits
  task automatic wait_ep(input logic [1:0] e);
    int n;
    n = 0;
    while (ext_pending !== e && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (ext_pending !== e) begin
      error_cnt++;
      $display("[FAIL] %0t external input timeout", $time);
      end_sim();
    end
    @(negedge ref_clk);
  endtask : wait_ep
  // ==========================================================
  // reference model: flags through masks and the global gate
  function automatic logic [16:0] exp_src(input logic [23:0] p, input logic [1:0] ep);
    logic [16:0] f;
    f = {|p[23:22], p[21], |p[20:19], |p[18:17], |p[16:15], p[14], p[13], p[12], p[11], p[10], |p[9:6],
      |p[5:4], |p[3:2], p[1], ep[1], p[0], ep[0]};
    return f & {sh[4][1:0], sh[3], sh[0][6:0]} & {17{sh[0][7]}};
  endfunction : exp_src
  // idle arbitration: high level first, then the lowest source number
  task automatic cmp_idle(input logic [16:0] e);
    logic [16:0] hi, s;
    int idx;
    hi = e & {sh[6][1:0], sh[5], sh[1][6:0]};
    s = (hi != 17'h0) ? hi : e;
    idx = 0;
    for (int k = 16; k >= 0; k--) begin
      if (s[k]) begin
        idx = k;
      end
    end
    check(src_request, e);
    check(irq_req, |e);
    if (|e) begin
      check(irq_high, |hi);
      check(irq_index, idx);
    end
  endtask : cmp_idle
  // ==========================================================
  // sequence
  initial begin
    seed = 32'h0a56;
    error_cnt = 0;
    check_count = 0;
    nrst = 1'b0;
    {sfr_wr_en, sfr_rd_en, bit_wr_en, bit_wdata, vector_ack, reti_done} = 6'h00;
    {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
    ext_edge_mode = 2'b00;
    flag_req = 24'h000000;
    pin_req = 8'hff;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    check(src_request, 17'h0);
    for (int r = 0; r < 7; r++) begin
      sh[r] = RST[r];
      rd(ADR[r], RST[r]);
    end
    rd(8'h00, 8'h00);
    $display("reset test done");
    for (int r = 0; r < 7; r++) begin
      repeat (3) begin
        rnd = $random(seed);
        wr(r, rnd[7:0]);
        rd(ADR[r], sh[r]);
      end
      wr(r, RST[r]);
    end
    bw(8'haf, 1'b1);
    bw(8'hbf, 1'b0);
    rd(8'ha8, sh[0]);
    rd(8'hb8, sh[1]);
    $display("register test done");
    // input config stays at reset so both external inputs idle
    for (int i = 0; i < 60; i++) begin
      for (int r = 0; r < 7; r++) begin
        rnd = $random(seed);
        if (r != 2) begin
          wr(r, rnd[7:0]);
        end
      end
      rnd = $random(seed);
      rnd2 = $random(seed);
      flag_req <= rnd[23:0] & rnd2[23:0];
      repeat (2) @(negedge ref_clk);
      cmp_idle(exp_src(flag_req, 2'b00));
    end
    $display("gating test done");
    for (int r = 1; r < 7; r++) begin
      if (r != 2) begin
        wr(r, 8'h00);
      end
    end
    wr(0, 8'h8a);
    bw(8'hb9, 1'b1);
    flag_req <= 24'h000002;
    repeat (2) @(negedge ref_clk);
    cmp_idle(exp_src(flag_req, 2'b00));
    pulse(1'b1, 1'b0);
    check(irq_req, 1'b0);
    flag_req <= 24'h000003;
    repeat (3) @(negedge ref_clk);
    check(irq_req, 1'b1);
    check(irq_index, 5'd1);
    pulse(1'b1, 1'b0);
    check(irq_req, 1'b0);
    flag_req <= 24'h000002;
    repeat (2) @(negedge ref_clk);
    pulse(1'b0, 1'b1);
    check(irq_req, 1'b0);
    pulse(1'b0, 1'b1);
    cmp_idle(exp_src(flag_req, 2'b00));
    $display("service test done");
    wr(0, 8'h85);
    pin_req <= 8'h20;
    repeat (8) @(negedge ref_clk);
    wr(2, 8'h8d);
    wait_ep(2'b01);
    check(src_request, exp_src(flag_req, 2'b01));
    pin_req <= 8'h01;
    wait_ep(2'b10);
    check(src_request, exp_src(flag_req, 2'b10));
    ext_edge_mode <= 2'b11;
    pin_req <= 8'h21;
    wait_ep(2'b11);
    pulse(1'b1, 1'b0);
    check(ext_pending, 2'b10);
    pulse(1'b0, 1'b1);
    check(irq_index, 5'(SRC_EXT1));
    pulse(1'b1, 1'b0);
    check(ext_pending, 2'b00);
    pulse(1'b0, 1'b1);
    $display("external input test done");
    end_sim();
  end
endmodule : tb
